// ===== core/core_memory_flags.sv
`timescale 1ns/1ps
// Purpose: data memory map, table reads, stack control and status flags
// Assumes: a sequencer outside issues one request per instruction cycle
// Notes: small_variant narrows the memory pointers to 7 bits
module core_memory_flags
  import core_pkg::*;
#(
  parameter bit small_variant = 1'b0
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  input wire core_pkg::alu_op_type alu_op,
  input wire logic [7:0] alu_addr,
  input wire logic alu_to_acc,
  input wire logic [7:0] imm,
  input wire logic use_imm,
  input wire logic tbl_current,
  input wire logic tbl_last,
  input wire logic [7:0] tbl_dest,
  output logic [11:0] rom_addr,
  output logic rom_rd,
  input wire logic [14:0] rom_data,
  output logic busy,
  input wire logic [11:0] pc,
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic timer1_irq,
  input wire logic timer1_en,
  output logic pc_load,
  output logic [11:0] pc_target,
  output logic irq_ack,
  input wire logic sleep_cmd,
  input wire logic watchdog_kick,
  input wire logic watchdog_expired,
  output logic cycle_strobe,
  output logic [7:0] accumulator_out,
  output logic stack_full
);
  // Table read sequencer states
  typedef enum logic [1:0] {tbl_idle, tbl_fetch, tbl_store} tbl_state_type;
  typedef struct packed {
    logic [1:0] phase;
    tbl_state_type tstate;
    logic [11:0] taddr;
    logic [7:0] tdest;
    logic [7:0] accumulator;
    logic [7:0] memory_pointer_0;
    logic [7:0] memory_pointer_1;
    logic [7:0] table_pointer;
    logic [6:0] table_high_byte;
    logic [5:0] status_flags;
    logic irq_pending;
    logic [7:0] rdata;
    logic [2:0] tcount;
  } state_type;
  state_type s_r;
  state_type s_nxt;
  // General purpose memory
  logic [7:0] ram [0:ram_depth-1];
  // ALU outputs
  logic [7:0] alu_y;
  logic alu_c;
  logic alu_ac;
  logic alu_z;
  logic alu_ov;
  logic alu_arith;
  logic [7:0] alu_b;
  // Stack wiring
  logic st_push;
  logic st_pop;
  logic [11:0] st_top;
  logic st_full;
  // Resolved addresses for reads and writes
  logic [7:0] rd_eff;
  logic [7:0] wr_eff;
  logic [7:0] wr_data;
  logic wr_en;
  logic [7:0] rd_val;
  logic [7:0] alu_src;
  logic ram_wr;
  logic [7:0] ram_idx;

  // --------------------------------------------------
  // Address resolution through the pointers
  // --------------------------------------------------
  function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] p0, input logic [7:0] p1);
    logic [7:0] r;
    r = a;
    if (a == addr_ind0) begin
      r = p0;
    end else if (a == addr_ind1) begin
      r = p1;
    end
    return r;
  endfunction

  // Pointer read value; small variant shows bit 7 as one
  function automatic logic [7:0] mp_view(input logic [7:0] v);
    return small_variant ? {1'b1, v[6:0]} : v;
  endfunction

  // --------------------------------------------------
  // Read multiplexer for a resolved address
  // --------------------------------------------------
  function automatic logic [7:0] read_at(input logic [7:0] a, input state_type s, input logic [7:0] ram_v);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      addr_ind0, addr_ind1: v = 8'h00;
      addr_mp0: v = mp_view(s.memory_pointer_0);
      addr_mp1: v = mp_view(s.memory_pointer_1);
      addr_acc: v = s.accumulator;
      addr_table_pointer: v = s.table_pointer;
      addr_table_high_byte: v = {1'b0, s.table_high_byte};
      addr_status: v = {2'b00, s.status_flags};
      default: begin
        if (a >= addr_ram_lo && a <= addr_ram_hi) begin
          v = ram_v;
        end
      end
    endcase
    return v;
  endfunction

  always_comb begin
    rd_eff = resolve(use_imm ? mem_addr : (alu_op != op_none ? alu_addr : mem_addr),
                     s_r.memory_pointer_0, s_r.memory_pointer_1);
  end
  assign ram_idx = (s_r.tstate == tbl_store) ? (s_r.tdest - addr_ram_lo)
                 : (wr_en ? (wr_eff - addr_ram_lo) : (rd_eff - addr_ram_lo));
  assign rd_val = read_at(rd_eff, s_r, ram[ram_idx]);
  assign alu_src = rd_val;
  assign alu_b = use_imm ? imm : alu_src;

  flag_alu u_alu (
    .op(alu_op),
    .a(s_r.accumulator),
    .b(alu_b),
    .cin(s_r.status_flags[c_bit]),
    .y(alu_y),
    .c(alu_c),
    .ac(alu_ac),
    .z(alu_z),
    .ov(alu_ov),
    .arith(alu_arith)
  );

  return_stack u_stack (
    .mclk(mclk),
    .rst(rst),
    .push(st_push),
    .pop(st_pop),
    .push_pc(pc),
    .top_pc(st_top),
    .full(st_full)
  );

  // --------------------------------------------------
  // Next-state logic
  // --------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    wr_en = 1'b0;
    wr_eff = 8'h00;
    wr_data = 8'h00;
    st_push = 1'b0;
    st_pop = 1'b0;
    pc_load = 1'b0;
    pc_target = 12'h000;
    irq_ack = 1'b0;
    // Divide the clock into four-phase instruction cycles
    s_nxt.phase = s_r.phase + 2'h1;
    // Timer interrupt request latches; set wins over acknowledge
    if (timer1_irq) begin
      s_nxt.irq_pending = 1'b1;
    end
    // Software write or ALU writeback; moves between locations go via accumulator
    if (mem_wr && s_r.tstate == tbl_idle) begin
      wr_en = 1'b1;
      wr_eff = resolve(mem_addr, s_r.memory_pointer_0, s_r.memory_pointer_1);
      wr_data = mem_wdata;
    end else if (alu_op != op_none && !alu_to_acc && !use_imm) begin
      wr_en = 1'b1;
      wr_eff = resolve(alu_addr, s_r.memory_pointer_0, s_r.memory_pointer_1);
      wr_data = alu_y;
    end
    if (alu_op != op_none && alu_to_acc) begin
      s_nxt.accumulator = alu_y;
    end
    if (wr_en) begin
      case (wr_eff)
        addr_ind0, addr_ind1: ;
        addr_mp0: s_nxt.memory_pointer_0 = small_variant ? {1'b0, wr_data[6:0]} : wr_data;
        addr_mp1: s_nxt.memory_pointer_1 = small_variant ? {1'b0, wr_data[6:0]} : wr_data;
        addr_acc: s_nxt.accumulator = wr_data;
        addr_table_pointer: s_nxt.table_pointer = wr_data;
        addr_status: begin
          // Sleep and timeout flags are not writable
          s_nxt.status_flags[3:0] = wr_data[3:0];
        end
        default: ;
      endcase
    end
    // Arithmetic flags from the ALU
    if (alu_op != op_none && alu_op != op_pass) begin
      s_nxt.status_flags[z_bit] = alu_z;
      if (alu_arith || alu_op == op_rlc || alu_op == op_rrc) begin
        s_nxt.status_flags[c_bit] = alu_c;
      end
      if (alu_arith) begin
        s_nxt.status_flags[ac_bit] = alu_ac;
        s_nxt.status_flags[ov_bit] = alu_ov;
      end
    end
    // Power and watchdog flags
    if (watchdog_kick) begin
      s_nxt.status_flags[pdf_bit] = 1'b0;
      s_nxt.status_flags[to_bit] = 1'b0;
    end else if (sleep_cmd) begin
      s_nxt.status_flags[pdf_bit] = 1'b1;
      s_nxt.status_flags[to_bit] = 1'b0;
    end
    if (watchdog_expired) begin
      s_nxt.status_flags[to_bit] = 1'b1;
    end
    // Calls, returns and the interrupt; only the PC is stacked
    if (ret_req) begin
      st_pop = 1'b1;
      pc_load = 1'b1;
      pc_target = st_top;
    end else if (call_req) begin
      st_push = 1'b1;
    end else if (s_r.irq_pending && timer1_en && !st_full && s_r.phase == 2'h3) begin
      st_push = 1'b1;
      pc_load = 1'b1;
      pc_target = vec_timer1;
      irq_ack = 1'b1;
      s_nxt.irq_pending = timer1_irq;
    end
    // Table read sequence
    case (s_r.tstate)
      tbl_idle: begin
        if (tbl_current || tbl_last) begin
          s_nxt.taddr = tbl_last ? {4'hf, s_r.table_pointer}
                                 : {pc[11:8], s_r.table_pointer};
          s_nxt.tdest = resolve(tbl_dest, s_r.memory_pointer_0, s_r.memory_pointer_1);
          s_nxt.tcount = 3'(clocks_per_cycle * table_cycles - 2);
          s_nxt.tstate = tbl_fetch;
        end
      end
      tbl_fetch: begin
        if (s_r.tcount == 3'h0) begin
          s_nxt.tstate = tbl_store;
        end else begin
          s_nxt.tcount = s_r.tcount - 3'h1;
        end
      end
      tbl_store: begin
        s_nxt.table_high_byte = rom_data[14:8];
        s_nxt.tstate = tbl_idle;
        case (s_r.tdest)
          addr_ind0, addr_ind1: ;
          addr_mp0: s_nxt.memory_pointer_0 = small_variant ? {1'b0, rom_data[6:0]} : rom_data[7:0];
          addr_mp1: s_nxt.memory_pointer_1 = small_variant ? {1'b0, rom_data[6:0]} : rom_data[7:0];
          addr_acc: s_nxt.accumulator = rom_data[7:0];
          addr_table_pointer: s_nxt.table_pointer = rom_data[7:0];
          addr_status: s_nxt.status_flags[3:0] = rom_data[3:0];
          default: ;
        endcase
      end
      default: s_nxt.tstate = tbl_idle;
    endcase
    // Registered read data
    if (mem_rd) begin
      s_nxt.rdata = rd_val;
    end
  end

  // RAM write path: table store has priority over the bus
  assign ram_wr = (s_r.tstate == tbl_store) ? (s_r.tdest >= addr_ram_lo && s_r.tdest <= addr_ram_hi)
                : (wr_en && wr_eff >= addr_ram_lo && wr_eff <= addr_ram_hi);

  // --------------------------------------------------
  // Registers
  // --------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
      s_r.tstate <= tbl_idle;
      s_r.status_flags <= status_reset;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Data memory array
  always_ff @(posedge mclk) begin
    if (ram_wr) begin
      ram[ram_idx] <= (s_r.tstate == tbl_store) ? rom_data[7:0] : wr_data;
    end
  end

  assign mem_rdata = s_r.rdata;
  assign rom_addr = s_r.taddr;
  assign rom_rd = (s_r.tstate == tbl_fetch);
  assign busy = (s_r.tstate != tbl_idle);
  assign cycle_strobe = (s_r.phase == 2'h3);
  assign accumulator_out = s_r.accumulator;
  assign stack_full = st_full;
endmodule

// ===== common/core_pkg.sv
// Purpose: constants shared by the core memory, stack and flag logic
// Assumes: one system clock, four clocks per instruction cycle
// Notes: data addresses are 8 bits, program addresses 12 bits
// Contract
// - Second timer overflow vectors to address 00CH
// - Current page table: PC[11:8] plus pointer
// - Last page table: upper bits forced one
// - Low byte to memory, upper to 08H
// - High byte reg read-only, top bits zero
// - Table pointer read/write at 07H
// - Table reads take two instruction cycles
// - Stack holds PC only, hidden, 8 levels
// - Call/interrupt push; returns pop PC
// - Reset leaves stack empty
// - Full stack holds interrupt until return
// - Call on full stack drops oldest
// - Unused low addresses read 00H; RAM 20H-BFH
// - 00H/02H access through pointers 01H/03H
// - Indirect to 00H reads zero, ignores writes
// - Small variant pointers keep 7 bits, bit7 reads one
// - Accumulator at 05H; moves pass through it
// - Status at 0AH with fixed flag layout
// - Status writes keep sleep and timeout flags
// - Carry from add, no-borrow, rotate-through
// - Overflow and zero flag rules
// - Sleep flag: kick clears, sleep sets
// - Timeout flag: kick/sleep clear, expiry sets
// - Status not saved on call or interrupt
// - Instruction cycle is four clocks
package core_pkg;
  localparam logic [7:0] addr_ind0 = 8'h00;
  localparam logic [7:0] addr_mp0 = 8'h01;
  localparam logic [7:0] addr_ind1 = 8'h02;
  localparam logic [7:0] addr_mp1 = 8'h03;
  localparam logic [7:0] addr_acc = 8'h05;
  localparam logic [7:0] addr_table_pointer = 8'h07;
  localparam logic [7:0] addr_table_high_byte = 8'h08;
  localparam logic [7:0] addr_status = 8'h0a;
  localparam logic [7:0] addr_ram_lo = 8'h20;
  localparam logic [7:0] addr_ram_hi = 8'hbf;
  localparam int ram_depth = 160;
  localparam logic [11:0] vec_timer1 = 12'h00c;
  localparam int stack_levels = 8;
  localparam int clocks_per_cycle = 4;
  localparam int table_cycles = 2;
  localparam int c_bit = 0;
  localparam int ac_bit = 1;
  localparam int z_bit = 2;
  localparam int ov_bit = 3;
  localparam int pdf_bit = 4;
  localparam int to_bit = 5;
  localparam logic [5:0] status_reset = 6'h00;
  // ALU operation codes
  typedef enum logic [3:0] {
    op_none, op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_xor,
    op_cpl, op_rlc, op_rrc, op_inc, op_dec, op_pass
  } alu_op_type;
endpackage

// ===== core/return_stack.sv
`timescale 1ns/1ps
// Purpose: hidden return address stack
// Assumes: push and pop never in the same cycle
// Notes: neither the entries nor the index are visible to software
module return_stack
  import core_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [11:0] push_pc,
  output logic [11:0] top_pc,
  output logic full
);
  typedef struct packed {
    logic [stack_levels-1:0][11:0] entry;
    logic [3:0] stack_index;
  } state_type;
  state_type s_r;
  state_type s_nxt;
  // --------------------------------------------------
  // Push and pop
  // --------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      if (s_r.stack_index == 4'(stack_levels)) begin
        // Shift out the oldest entry
        for (int i = 0; i < stack_levels - 1; i++) begin
          s_nxt.entry[i] = s_r.entry[i+1];
        end
        s_nxt.entry[stack_levels-1] = push_pc;
      end else begin
        s_nxt.entry[s_r.stack_index[2:0]] = push_pc;
        s_nxt.stack_index = s_r.stack_index + 4'h1;
      end
    end else if (pop && s_r.stack_index != 4'h0) begin
      s_nxt.stack_index = s_r.stack_index - 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign top_pc = (s_r.stack_index == 4'h0) ? 12'h000 : s_r.entry[s_r.stack_index[2:0] - 3'h1];
  assign full = (s_r.stack_index == 4'(stack_levels));
endmodule

// ===== core/flag_alu.sv
`timescale 1ns/1ps
// Purpose: 8-bit ALU producing result and arithmetic flags
// Assumes: operand a is registered by the caller; b may come straight from imm or a memory read
// Notes: pure combinational
module flag_alu
  import core_pkg::*;
(
  input wire alu_op_type op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] y,
  output logic c,
  output logic ac,
  output logic z,
  output logic ov,
  output logic arith
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] bb;
  logic ci;
  // --------------------------------------------------
  // Operation select
  // --------------------------------------------------
  always_comb begin
    bb = b;
    ci = 1'b0;
    y = a;
    c = cin;
    arith = 1'b0;
    sum = 9'h000;
    nib = 5'h00;
    case (op)
      op_add, op_adc, op_sub, op_sbc: begin
        // Subtract is add of inverse with carry in; carry out means no borrow
        bb = (op == op_sub || op == op_sbc) ? ~b : b;
        ci = (op == op_sub) ? 1'b1 : ((op == op_add) ? 1'b0 : cin);
        sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        y = sum[7:0];
        c = sum[8];
        arith = 1'b1;
      end
      op_and: y = a & b;
      op_or: y = a | b;
      op_xor: y = a ^ b;
      op_cpl: y = ~a;
      op_inc: y = a + 8'h01;
      op_dec: y = a - 8'h01;
      op_rlc: begin
        y = {a[6:0], cin};
        c = a[7];
      end
      op_rrc: begin
        y = {cin, a[7:1]};
        c = a[0];
      end
      default: y = a;
    endcase
  end
  assign ac = nib[4];
  // Carry into bit 7 differs from carry out of it
  assign ov = (a[7] ^ bb[7] ^ sum[7]) ^ sum[8];
  assign z = (y == 8'h00);
endmodule

// ===== tb/core_memory_flags_chk.sv
// Purpose: port-level checks on the core memory, stack and flag block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module core_memory_flags_chk
  import core_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic tbl_current,
  input wire logic tbl_last,
  input wire logic [11:0] rom_addr,
  input wire logic busy,
  input wire logic [11:0] pc,
  input wire logic ret_req,
  input wire logic pc_load,
  input wire logic [11:0] pc_target,
  input wire logic irq_ack,
  input wire logic cycle_strobe,
  input wire logic stack_full
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Shadow of the table pointer
  // ----------------------------------------
  logic [7:0] table_pointer_r; // Last accepted pointer write
  logic [7:0] table_pointer_nxt;
  // Writes are dropped while a table read runs
  always_comb table_pointer_nxt = (mem_wr && !busy && mem_addr == addr_table_pointer) ? mem_wdata : table_pointer_r;
  always_ff @(posedge mclk) table_pointer_r <= rst ? 8'h00 : table_pointer_nxt;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  busy_length_a: assert property (tbl_current && !busy |=> busy [*8] ##1 !busy)
    else $error("table read busy length wrong");
  cur_page_a: assert property (tbl_current && !busy |=> rom_addr == {$past(pc[11:8]), table_pointer_r})
    else $error("current page table address wrong");
  last_page_a: assert property (tbl_last && !busy |=> rom_addr == {4'hf, table_pointer_r})
    else $error("last page table address wrong");
  ret_load_a: assert property (ret_req |-> pc_load)
    else $error("return without program counter load");
  irq_vector_a: assert property (irq_ack |-> pc_load && pc_target == vec_timer1)
    else $error("interrupt vector wrong");
  irq_not_full_a: assert property (irq_ack |-> !stack_full && cycle_strobe)
    else $error("interrupt acknowledged on full stack");
  strobe_period_a: assert property (cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe)
    else $error("instruction cycle not four clocks");
  status_top_a: assert property (mem_rd && mem_addr == addr_status |=> mem_rdata[7:6] == 2'b00)
    else $error("status top bits not zero");
  high_top_a: assert property (mem_rd && mem_addr == addr_table_high_byte |=> !mem_rdata[7])
    else $error("high byte unused bit not zero");
  unmapped_zero_a: assert property (mem_rd && mem_addr == 8'h04 |=> mem_rdata == 8'h00)
    else $error("unused address not zero");
  tbl_cur_c: cover property (tbl_current && !busy);
  tbl_last_c: cover property (tbl_last && !busy);
  irq_ack_c: cover property (irq_ack);
endmodule
bind core_memory_flags core_memory_flags_chk chk_u (.mclk(mclk), .rst(rst), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .tbl_current(tbl_current), .tbl_last(tbl_last), .rom_addr(rom_addr), .busy(busy), .pc(pc),
  .ret_req(ret_req), .pc_load(pc_load), .pc_target(pc_target), .irq_ack(irq_ack),
  .cycle_strobe(cycle_strobe), .stack_full(stack_full));

// ===== tb/core_memory_flags_tb_top.sv
// Purpose: directed test of memory map, table reads, stack and flags
// Assumes: inputs change on the falling clock edge
// Notes: stack and interrupt checks end with a reset to empty the stack
`timescale 1ns/1ps
module core_memory_flags_tb_top;
  import core_pkg::*;
  logic mclk, rst, mem_rd, mem_wr, alu_to_acc, use_imm, tbl_current, tbl_last, busy, rom_rd;
  logic [7:0] mem_addr, mem_wdata, mem_rdata, alu_addr, imm, tbl_dest, accumulator_out;
  logic [11:0] rom_addr, pc, pc_target;
  logic [14:0] rom_data;
  logic call_req, ret_req, timer1_irq, timer1_en, pc_load, irq_ack, sleep_cmd, watchdog_kick;
  logic watchdog_expired, cycle_strobe, stack_full;
  alu_op_type alu_op;
  int mismatches, n_compared, n;
  core_memory_flags #(.small_variant(1'b0)) dut_u (.mclk(mclk), .rst(rst), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .alu_op(alu_op),
    .alu_addr(alu_addr), .alu_to_acc(alu_to_acc), .imm(imm), .use_imm(use_imm),
    .tbl_current(tbl_current), .tbl_last(tbl_last), .tbl_dest(tbl_dest), .rom_addr(rom_addr),
    .rom_rd(rom_rd), .rom_data(rom_data), .busy(busy), .pc(pc), .call_req(call_req),
    .ret_req(ret_req), .timer1_irq(timer1_irq), .timer1_en(timer1_en), .pc_load(pc_load),
    .pc_target(pc_target), .irq_ack(irq_ack), .sleep_cmd(sleep_cmd), .watchdog_kick(watchdog_kick),
    .watchdog_expired(watchdog_expired), .cycle_strobe(cycle_strobe),
    .accumulator_out(accumulator_out), .stack_full(stack_full));
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare one value and report a mismatch at once
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    {mem_addr, mem_wdata, mem_wr} = {a, d, 1'b1};
    @(negedge mclk);
    mem_wr = 1'b0;
  endtask
  // Read data is registered, so it is looked at one clock later
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    {mem_addr, mem_rd} = {a, 1'b1};
    @(negedge mclk);
    mem_rd = 1'b0;
    chk($sformatf("read %h", a), {4'h0, exp}, {4'h0, mem_rdata});
  endtask
  // One-clock pulse on sleep, kick and expiry
  task automatic ev(input logic [2:0] s);
    @(negedge mclk);
    {sleep_cmd, watchdog_kick, watchdog_expired} = s;
    @(negedge mclk);
    {sleep_cmd, watchdog_kick, watchdog_expired} = 3'b000;
  endtask
  task automatic alu(input logic [7:0] a, input logic [7:0] b, input alu_op_type op,
                     input logic [7:0] ey, input logic [3:0] ef);
    wr(addr_acc, a);
    @(negedge mclk);
    alu_op = op;
    {imm, use_imm, alu_to_acc} = {b, 2'b11};
    @(negedge mclk);
    alu_op = op_none;
    chk("alu result", {4'h0, ey}, {4'h0, accumulator_out});
    rdc(addr_status, {4'h0, ef});
  endtask
  task automatic tbl(input logic last, input logic [11:0] ea, input logic [14:0] w);
    @(negedge mclk);
    {tbl_dest, rom_data, tbl_last, tbl_current} = {8'h30, w, last, !last};
    @(negedge mclk);
    {tbl_last, tbl_current} = 2'b00;
    chk("table address", ea, rom_addr);
    chk("rom read", 12'h1, {11'h0, rom_rd});
    for (n = 0; busy === 1'b1 && n < 20; n++) @(negedge mclk);
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end
    chk("busy cycles", 12'd8, n[11:0]);
    rdc(8'h30, w[7:0]);
    rdc(addr_table_high_byte, {1'b0, w[14:8]});
  endtask
  task automatic call(input logic [11:0] p);
    @(negedge mclk);
    {pc, call_req} = {p, 1'b1};
    @(negedge mclk);
    call_req = 1'b0;
  endtask
  // Return: only the target is looked at while the request stands
  task automatic ret(input logic [11:0] ep);
    @(negedge mclk);
    ret_req = 1'b1;
    #10;
    chk("return target", ep, pc_target);
    @(negedge mclk);
    ret_req = 1'b0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {mem_rd, mem_wr, alu_to_acc, use_imm, tbl_current, tbl_last, call_req, ret_req} = 8'h00;
    {timer1_irq, timer1_en, sleep_cmd, watchdog_kick, watchdog_expired} = 5'h00;
    {mem_addr, mem_wdata, alu_addr, imm, tbl_dest} = 40'h0;
    {pc, rom_data} = 27'h0;
    alu_op = op_none;
    mismatches = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    chk("stack full after reset", 12'h0, {11'h0, stack_full});
    rdc(addr_status, 8'h00);
    wr(addr_table_pointer, 8'h44);
    rdc(addr_table_pointer, 8'h44);
    wr(addr_table_high_byte, 8'hff);
    rdc(addr_table_high_byte, 8'h00);
    rdc(8'h04, 8'h00);
    wr(addr_ram_hi, 8'h3c);
    rdc(addr_ram_hi, 8'h3c);
    wr(addr_mp0, 8'h20);
    wr(addr_ind0, 8'h5a);
    rdc(8'h20, 8'h5a);
    wr(addr_mp1, 8'h21);
    wr(addr_ind1, 8'hc3);
    rdc(addr_ind1, 8'hc3);
    wr(addr_mp0, 8'h00);
    wr(addr_ind0, 8'h77);
    rdc(addr_ind0, 8'h00);
    wr(addr_acc, 8'h99);
    rdc(addr_acc, 8'h99);
    alu(8'h7f, 8'h01, op_add, 8'h80, 4'ha);
    alu(8'h80, 8'h80, op_add, 8'h00, 4'hd);
    alu(8'h00, 8'h00, op_sub, 8'h00, 4'h7);
    // Rotate through carry takes the old carry in and leaves bit 7 in carry
    alu(8'h81, 8'h00, op_rlc, 8'h03, 4'h3);
    alu(8'hf0, 8'h0f, op_and, 8'h00, 4'h7);
    wr(addr_status, 8'hff);
    rdc(addr_status, 8'h0f);
    ev(3'b100);
    ev(3'b001);
    rdc(addr_status, 8'h3f);
    wr(addr_status, 8'h00);
    rdc(addr_status, 8'h30);
    ev(3'b100);
    rdc(addr_status, 8'h10);
    ev(3'b001);
    ev(3'b010);
    rdc(addr_status, 8'h00);
    pc = 12'h3aa;
    tbl(1'b0, 12'h344, 15'h5a3c);
    tbl(1'b1, 12'hf44, 15'h4321);
    // Ninth call overflows and loses the oldest address
    for (int i = 0; i < 9; i++) call(12'h100 + 12'(i));
    for (int i = 8; i > 0; i--) ret(12'h100 + 12'(i));
    // Interrupt held while the stack is full, taken after a return
    for (int i = 0; i < 8; i++) call(12'h200 + 12'(i));
    chk("stack full", 12'h1, {11'h0, stack_full});
    {pc, timer1_en} = {12'h3aa, 1'b1};
    @(negedge mclk);
    timer1_irq = 1'b1;
    @(negedge mclk);
    timer1_irq = 1'b0;
    for (n = 0; irq_ack !== 1'b1 && n < 12; n++) @(negedge mclk);
    chk("ack on full stack", 12'd12, n[11:0]);
    ret(12'h207);
    for (n = 0; irq_ack !== 1'b1 && n < 20; n++) @(negedge mclk);
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end
    chk("vector", vec_timer1, pc_target);
    @(negedge mclk);
    ret(12'h3aa);
    rdc(addr_status, 8'h00);
    // Fill the stack again so that the reset has something to empty
    call(12'h300);
    chk("stack full before reset", 12'h1, {11'h0, stack_full});
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    chk("stack full after reset", 12'h0, {11'h0, stack_full});
    print_verdict();
  end
endmodule
